// [logic/amcs_defs.svh]
// constant definitions for the adc mode and channel sequencer
`ifndef AMCS_DEFS_SVH
`define AMCS_DEFS_SVH

// ------------------------------------------------------------------
// command words, as the host writes them in the first 16 bits
// ------------------------------------------------------------------
`define AMCS_CMD_HOLD      16'h0000 // hold_mode_word: keep mode and settings
`define AMCS_CMD_STANDBY   16'h8200 // standby_cmd
`define AMCS_CMD_PWRDN     16'h8300 // power_down_cmd
`define AMCS_CMD_RESET     16'h8500 // program register reset
`define AMCS_CMD_AUTO      16'ha000 // auto scan with restart
`define AMCS_CMD_AUX       16'he000 // manual_aux_select_cmd
`define AMCS_MAN_PREFIX    3'h6     // top bits of manual_channel_select_cmd
`define AMCS_MAN_TOP       15       // msb of the manual prefix field
`define AMCS_MAN_PRE_LSB   13       // lsb of the manual prefix field
`define AMCS_MAN_CH_MSB    12       // msb of the channel number field
`define AMCS_MAN_CH_LSB    10       // lsb of the channel number field
`define AMCS_MAN_LOW_MSB   9        // msb of the must-be-zero tail
`define AMCS_MAN_LOW_ZERO  10'h000  // tail value of a manual select word
`define AMCS_PROG_FLAG     15       // clear in a program register access

// ------------------------------------------------------------------
// frame lengths, channel codes and reset values
// ------------------------------------------------------------------
`define AMCS_CMD_BITS      6'h10    // bits in a command word
`define AMCS_FULL_FRAME    6'h20    // serial clocks in a full frame
`define AMCS_CNT_ONE       6'h01    // bit count after the first edge
`define AMCS_AUX_CH        4'h8     // channel code of the auxiliary input
`define AMCS_INVALID_DATA  16'hffff // shifted out when nothing converts
`define AMCS_CS_IDLE       1'b1     // chip select level between frames
`define AMCS_PIN_IDLE      1'b1     // reset pin level when inactive
`define AMCS_NUM_CH        8        // analog channels

`endif

// [logic/amcs_pkg.sv]
// types shared by the adc mode and channel sequencer
`default_nettype none
package amcs_pkg;

	// ------------------------------------------------------------------
	// operating modes and decoded command classes
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		AMCS_MODE_RESET = 3'b000, // default state after any reset
		AMCS_MODE_STBY  = 3'b001, // standby
		AMCS_MODE_PWRDN = 3'b010, // powered down
		AMCS_MODE_AUTO  = 3'b011, // automatic scan
		AMCS_MODE_MAN   = 3'b100  // fixed channel
	} amcs_mode_t;

	typedef enum logic [2:0] {
		AMCS_CMD_C_HOLD  = 3'b000, // all-zero word
		AMCS_CMD_C_STBY  = 3'b001, // standby word
		AMCS_CMD_C_PWRDN = 3'b010, // power-down word
		AMCS_CMD_C_RST   = 3'b011, // register reset word
		AMCS_CMD_C_AUTO  = 3'b100, // auto scan word
		AMCS_CMD_C_MAN   = 3'b101, // channel or aux select
		AMCS_CMD_C_PROG  = 3'b110, // program register access
		AMCS_CMD_C_BAD   = 3'b111  // matches no encoding
	} amcs_cmd_t;

	// ------------------------------------------------------------------
	// state of the core-clock logic
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        cs_meta;        // chip select, first sync stage
		logic        cs_sync;        // chip select, second sync stage
		logic        cs_prev;        // delayed copy for edge detection
		logic        rp_meta;        // reset pin, first sync stage
		logic        rp_sync;        // reset pin, second sync stage
		logic        hw_pd;          // hardware power-down was active
		amcs_mode_t  mode;           // current operating mode
		logic [2:0]  scan_ch;        // auto scan position
		logic [3:0]  man_ch;         // manual channel, 8 = aux
		logic [15:0] cmd_reg;        // last mode command word; hold and register access words do not load it
		logic        sample_strobe;  // one-cycle sample pulse
		logic [3:0]  sample_channel; // channel being sampled
		logic [7:0]  ch_power_en;    // per channel power enables
		logic        prog_reset;     // program register reset pulse
		logic        prog_req;       // program register access pulse
		logic [15:0] prog_word;      // word of that access
		logic [15:0] sdo_word;       // word shifted out in the frame just started
		logic        sdo_oe;         // serial output drive enable
	} amcs_core_t;

	// ------------------------------------------------------------------
	// state of the serial-clock logic
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] cmd;   // received command bits
		logic [5:0]  count; // serial clocks seen, saturating
		logic [15:0] shift; // outgoing data
		logic        sdo;   // serial output bit
	} amcs_link_t;

endpackage : amcs_pkg
`default_nettype wire

// [logic/amcs_link.sv]
// serial-clock side of the sequencer: command capture and output shift
`timescale 1ns/1ps
`default_nettype none
`include "amcs_defs.svh"

module amcs_link (
	input  wire logic        sclk,      // serial clock from the host
	input  wire logic        cs_b,      // chip select, active low
	input  wire logic        sdi,       // serial data in
	input  wire logic [15:0] load_word, // core word, still while cs is high
	output logic             sdo,       // serial data out, from a flop
	output logic [15:0]      cmd_word,  // first 16 bits of the frame
	output logic [5:0]       bit_count  // serial clocks in the frame
);
	import amcs_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	amcs_link_t r;      // registered state
	amcs_link_t next_r; // next state
	logic       armed;  // set between frames, marks the first edge

	// the clock stops outside frames, so chip select itself re-arms
	always_ff @(posedge sclk or posedge cs_b) begin
		if (cs_b) begin
			armed <= 1'b1;
		end else begin
			armed <= 1'b0;
		end
	end

	// shift in command bits and shift out the core word
	always_comb begin
		next_r = r;
		if (armed) begin
			// first edge: new frame, load output word
			next_r.count = `AMCS_CNT_ONE;
			next_r.cmd   = {r.cmd[14:0] & 15'h0000, sdi};
			next_r.sdo   = load_word[15];
			next_r.shift = {load_word[14:0], 1'b0};
		end else begin
			if (r.count < `AMCS_CMD_BITS) begin
				next_r.cmd = {r.cmd[14:0], sdi};
			end
			if (r.count < `AMCS_FULL_FRAME) begin
				next_r.count = r.count + `AMCS_CNT_ONE;
			end
			next_r.sdo   = r.shift[15];
			next_r.shift = {r.shift[14:0], 1'b0};
		end
	end

	// register the link state
	always_ff @(posedge sclk) begin
		r <= next_r;
	end

	assign sdo       = r.sdo;
	assign cmd_word  = r.cmd;
	assign bit_count = r.count;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	chk_cmd_shift: assert property (@(posedge sclk) disable iff (cs_b)
		(!armed && r.count < `AMCS_CMD_BITS) |=> r.cmd[0] == $past(sdi))
		else $error("command bit not captured");

endmodule : amcs_link
`default_nettype wire

// [logic/amcs_sequencer.sv]
// mode and channel sequencer of an eight channel sar adc
`timescale 1ns/1ps
`default_nettype none
`include "amcs_defs.svh"

module amcs_sequencer (
	input  wire logic                 core_clk,              // core clock, 10 MHz
	input  wire logic                 rst_b,                 // sync reset, active low
	input  wire logic                 sclk,                  // serial clock from host
	input  wire logic                 cs_b,                  // chip select, active low
	input  wire logic                 sdi,                   // serial data in
	input  wire logic                 reset_powerdown_pin_b, // reset/power-down pin
	input  wire logic [7:0]           auto_seq_en,           // channels in the auto scan
	input  wire logic [15:0]          conv_data,             // conversion result
	output logic                      sdo,                   // serial data out
	output logic                      sdo_oe,                // drive enable for sdo
	output amcs_pkg::amcs_mode_t      mode,                  // current operating mode
	output logic                      sample_strobe,         // sample pulse, one cycle
	output logic [3:0]                sample_channel,        // channel sampled, 8 = aux
	output logic [7:0]                ch_power_en,           // per channel power enables
	output logic                      prog_reset,            // register reset pulse
	output logic                      prog_req,              // register access pulse
	output logic [15:0]               prog_word              // register access word
);
	import amcs_pkg::*;

	// ------------------------------------------------------------------
	// state and helpers
	// ------------------------------------------------------------------
	amcs_core_t  r;         // registered state
	amcs_core_t  next_r;    // next state
	logic [15:0] link_cmd;  // command word from the link side
	logic [5:0]  link_cnt;  // clock count from the link side
	logic        cs_rise;   // end of a frame seen
	logic        cs_fall;   // start of a frame seen
	logic        take;      // frame carried a whole command
	amcs_cmd_t   cmd_class; // decoded command class

	// reset values of the whole state
	localparam amcs_core_t CORE_RST = '{
		cs_meta:  `AMCS_CS_IDLE,
		cs_sync:  `AMCS_CS_IDLE,
		cs_prev:  `AMCS_CS_IDLE,
		rp_meta:  `AMCS_PIN_IDLE,
		rp_sync:  `AMCS_PIN_IDLE,
		mode:     AMCS_MODE_RESET,
		sdo_word: `AMCS_INVALID_DATA,
		default:  '0
	};

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------
	// lowest enabled channel, zero when none is enabled
	function automatic logic [2:0] lowest_enabled(input logic [7:0] mask);
		logic [2:0] ch;
		ch = 3'h0;
		for (int i = `AMCS_NUM_CH - 1; i >= 0; i--) begin
			if (mask[i]) begin
				ch = 3'(i);
			end
		end
		return ch;
	endfunction : lowest_enabled

	// next enabled channel after cur, wrapping round
	function automatic logic [2:0] next_enabled(input logic [2:0] cur,
	                                            input logic [7:0] mask);
		logic [2:0] ch;
		logic       found;
		logic [2:0] cand;
		ch    = cur;
		found = 1'b0;
		cand  = cur;
		for (int i = 1; i <= `AMCS_NUM_CH; i++) begin
			cand = cur + 3'(i);
			if (mask[cand] && !found) begin
				ch    = cand;
				found = 1'b1;
			end
		end
		return ch;
	endfunction : next_enabled

	// sort a command word into its class
	function automatic amcs_cmd_t decode_cmd(input logic [15:0] w);
		amcs_cmd_t c;
		c = AMCS_CMD_C_BAD;
		if (w == `AMCS_CMD_HOLD) begin
			c = AMCS_CMD_C_HOLD;
		end else if (w == `AMCS_CMD_STANDBY) begin
			c = AMCS_CMD_C_STBY;
		end else if (w == `AMCS_CMD_PWRDN) begin
			c = AMCS_CMD_C_PWRDN;
		end else if (w == `AMCS_CMD_RESET) begin
			c = AMCS_CMD_C_RST;
		end else if (w == `AMCS_CMD_AUTO) begin
			c = AMCS_CMD_C_AUTO;
		end else if (w == `AMCS_CMD_AUX) begin
			c = AMCS_CMD_C_MAN;
		end else if (w[`AMCS_MAN_TOP:`AMCS_MAN_PRE_LSB] == `AMCS_MAN_PREFIX
		             && w[`AMCS_MAN_LOW_MSB:0] == `AMCS_MAN_LOW_ZERO) begin
			c = AMCS_CMD_C_MAN;
		end else if (!w[`AMCS_PROG_FLAG]) begin
			c = AMCS_CMD_C_PROG;
		end
		return c;
	endfunction : decode_cmd

	// channel code carried by a manual select word
	function automatic logic [3:0] manual_channel(input logic [15:0] w);
		logic [3:0] ch;
		ch = {1'b0, w[`AMCS_MAN_CH_MSB:`AMCS_MAN_CH_LSB]};
		if (w == `AMCS_CMD_AUX) begin
			ch = `AMCS_AUX_CH;
		end
		return ch;
	endfunction : manual_channel

	// ------------------------------------------------------------------
	// serial clock side
	// ------------------------------------------------------------------
	// sdo_word only changes while the link clock stands still
	amcs_link u_link (
		.sclk      (sclk),
		.cs_b      (cs_b),
		.sdi       (sdi),
		.load_word (r.sdo_word),
		.sdo       (sdo),
		.cmd_word  (link_cmd),
		.bit_count (link_cnt)
	);

	// ------------------------------------------------------------------
	// frame edges and command decode
	// ------------------------------------------------------------------
	// edges come from the second sync stage and its delayed copy
	always_comb begin
		cs_rise   = r.cs_sync && !r.cs_prev;
		cs_fall   = !r.cs_sync && r.cs_prev;
		take      = cs_rise && (link_cnt >= `AMCS_CMD_BITS);
		cmd_class = decode_cmd(link_cmd);
	end

	// ------------------------------------------------------------------
	// mode and channel sequencing
	// ------------------------------------------------------------------
	always_comb begin
		next_r = r;
		// synchronisers; first stage feeds only the second
		next_r.cs_meta = cs_b;
		next_r.cs_sync = r.cs_meta;
		next_r.cs_prev = r.cs_sync;
		next_r.rp_meta = reset_powerdown_pin_b;
		next_r.rp_sync = r.rp_meta;
		// pulses default low
		next_r.sample_strobe = 1'b0;
		next_r.prog_reset    = 1'b0;
		next_r.prog_req      = 1'b0;
		// drive sdo only inside a frame
		next_r.sdo_oe = !r.cs_sync;
		// unscanned channels go down while scanning
		if (r.mode == AMCS_MODE_AUTO) begin
			next_r.ch_power_en = auto_seq_en;
		end else if (r.mode == AMCS_MODE_MAN) begin
			next_r.ch_power_en = 8'hff;
		end else begin
			next_r.ch_power_en = 8'h00;
		end

		if (!r.rp_sync) begin
			// hardware power-down: registers to defaults
			next_r.mode       = AMCS_MODE_PWRDN;
			next_r.hw_pd      = 1'b1;
			next_r.prog_reset = 1'b1;
			next_r.scan_ch    = 3'h0;
			next_r.man_ch     = 4'h0;
			next_r.cmd_reg    = `AMCS_CMD_HOLD;
			next_r.sdo_word   = `AMCS_INVALID_DATA;
		end else if (r.hw_pd) begin
			// pin released: wake in the default state
			next_r.hw_pd = 1'b0;
			next_r.mode  = AMCS_MODE_RESET;
		end else begin
			// frame start: sample per the mode set last frame
			if (cs_fall) begin
				unique case (r.mode)
					AMCS_MODE_AUTO: begin
						next_r.sample_strobe  = 1'b1;
						next_r.sample_channel = {1'b0, r.scan_ch};
						next_r.sdo_word       = conv_data;
						next_r.scan_ch = next_enabled(r.scan_ch, auto_seq_en);
					end
					AMCS_MODE_MAN: begin
						next_r.sample_strobe  = 1'b1;
						next_r.sample_channel = r.man_ch;
						next_r.sdo_word       = conv_data;
					end
					AMCS_MODE_RESET, AMCS_MODE_STBY, AMCS_MODE_PWRDN: begin
						next_r.sdo_word = `AMCS_INVALID_DATA;
					end
				endcase
			end
			// frame end: execute a complete command
			if (take) begin
				unique case (cmd_class)
					AMCS_CMD_C_HOLD: begin
						// keep mode and settings
						next_r.mode = r.mode;
					end
					AMCS_CMD_C_STBY: begin
						next_r.mode    = AMCS_MODE_STBY;
						next_r.cmd_reg = link_cmd;
					end
					AMCS_CMD_C_PWRDN: begin
						next_r.mode    = AMCS_MODE_PWRDN;
						next_r.cmd_reg = link_cmd;
					end
					AMCS_CMD_C_RST: begin
						next_r.mode       = AMCS_MODE_RESET;
						next_r.prog_reset = 1'b1;
						next_r.scan_ch    = 3'h0;
						next_r.cmd_reg    = link_cmd;
					end
					AMCS_CMD_C_AUTO: begin
						next_r.mode    = AMCS_MODE_AUTO;
						next_r.scan_ch = lowest_enabled(auto_seq_en);
						next_r.cmd_reg = link_cmd;
					end
					AMCS_CMD_C_MAN: begin
						next_r.mode    = AMCS_MODE_MAN;
						next_r.man_ch  = manual_channel(link_cmd);
						next_r.cmd_reg = link_cmd;
					end
					AMCS_CMD_C_PROG: begin
						// register access in any mode
						next_r.prog_req  = 1'b1;
						next_r.prog_word = link_cmd;
					end
					AMCS_CMD_C_BAD: begin
						// unknown word, nothing changes
						next_r.mode = r.mode;
					end
				endcase
			end
		end
	end

	// register the core state
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			r <= CORE_RST;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------------
	// outputs, all straight from flops
	// ------------------------------------------------------------------
	assign sdo_oe         = r.sdo_oe;
	assign mode           = r.mode;
	assign sample_strobe  = r.sample_strobe;
	assign sample_channel = r.sample_channel;
	assign ch_power_en    = r.ch_power_en;
	assign prog_reset     = r.prog_reset;
	assign prog_req       = r.prog_req;
	assign prog_word      = r.prog_word;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	logic awake; // pin idle and not waking
	assign awake = r.rp_sync && !r.hw_pd;

	chk_pd_exit: assert property (
		(awake && r.mode == AMCS_MODE_PWRDN && take
		 && (cmd_class == AMCS_CMD_C_AUTO || cmd_class == AMCS_CMD_C_MAN))
		|=> r.mode != AMCS_MODE_PWRDN)
		else $error("power-down not left on valid command");

	chk_auto_enter: assert property (
		(awake && take && cmd_class == AMCS_CMD_C_AUTO)
		|=> r.mode == AMCS_MODE_AUTO && r.scan_ch == lowest_enabled($past(auto_seq_en)))
		else $error("auto scan not entered at lowest channel");

	chk_mode_hold: assert property (
		(awake && take && cmd_class == AMCS_CMD_C_HOLD) |=> $stable(r.mode))
		else $error("hold word changed the mode");

	chk_auto_step: assert property (
		(awake && cs_fall && r.mode == AMCS_MODE_AUTO)
		|=> r.sample_strobe
		    && r.sample_channel == {1'b0, $past(r.scan_ch)}
		    && r.scan_ch == next_enabled($past(r.scan_ch), $past(auto_seq_en)))
		else $error("auto scan did not sample and advance");

	chk_chan_power: assert property (
		(r.mode == AMCS_MODE_AUTO && $stable(auto_seq_en))
		##1 (r.mode == AMCS_MODE_AUTO) |-> ch_power_en == $past(auto_seq_en))
		else $error("channel power enables do not follow the scan");

	chk_man_sample: assert property (
		(awake && cs_fall && r.mode == AMCS_MODE_MAN)
		|=> r.sample_strobe && r.sample_channel == $past(r.man_ch))
		else $error("manual channel not sampled at frame start");

	chk_soft_reset: assert property (
		(awake && take && cmd_class == AMCS_CMD_C_RST)
		|=> r.prog_reset && r.mode == AMCS_MODE_RESET && r.scan_ch == 3'h0
		##1 !r.prog_reset)
		else $error("software reset not executed as one pulse");

	chk_invalid_out: assert property (
		(awake && cs_fall && r.mode != AMCS_MODE_AUTO && r.mode != AMCS_MODE_MAN)
		|=> r.sdo_word == `AMCS_INVALID_DATA && !r.sample_strobe)
		else $error("idle mode did not return invalid data");

	chk_pin_reset: assert property (
		(!r.rp_sync) |=> r.prog_reset && r.mode == AMCS_MODE_PWRDN)
		else $error("reset pin did not reset registers");

	chk_bad_word: assert property (
		(awake && take && cmd_class == AMCS_CMD_C_BAD)
		|=> $stable(r.mode) && $stable(r.scan_ch) && $stable(r.man_ch))
		else $error("unknown word changed the state");

	cov_auto_restart: cover property (
		r.mode == AMCS_MODE_AUTO && take && cmd_class == AMCS_CMD_C_AUTO);
	cov_manual_frame: cover property (
		r.mode == AMCS_MODE_MAN && cs_fall);
	cov_reset_prog: cover property (
		r.mode == AMCS_MODE_RESET && take && cmd_class == AMCS_CMD_C_PROG);

endmodule : amcs_sequencer
`default_nettype wire

// [verification/amcs_host_model.sv]
// host controller model: frames on chip select, link clock and serial input
`timescale 1ns/1ps
`default_nettype none

module amcs_host_model (
	output logic      sclk, // link clock, still between frames
	output logic      cs_b, // chip select, active low
	output logic      sdi,  // command bits, msb first
	input  wire logic sdo   // device data out
);
	// idle lines at time zero
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		sdi  = 1'b0;
	end

	// -----------------------------------------------------------
	// one frame of n link clocks at 64 ns, first 16 output bits kept
	// -----------------------------------------------------------
	task automatic frame(input logic [15:0] w, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		#10 cs_b = 1'b0; // fall clear of the core clock edge
		#500; // let the device load its output word first
		for (int i = 0; i < n; i++) begin
			sdi = (i < 16) ? w[15 - i] : 1'b0; // zero tail keeps the mode
			#32 sclk = 1'b1;
			#16 if (i < 16) rx[15 - i] = sdo;
			#16 sclk = 1'b0;
		end
		#32 cs_b = 1'b1; // command acts on this rise
		sdi = ~sdi; // released line shows no stale level
	endtask : frame
endmodule : amcs_host_model
`default_nettype wire

// [verification/adc_mode_channel_sequencer_tb_top.sv]
// self-checking bench of the mode and channel sequencer
`timescale 1ns/1ps
`default_nettype none

module adc_mode_channel_sequencer_tb_top;
	import amcs_pkg::*;
	logic core_clk = 1'b0, rst_b = 1'b0, reset_powerdown_pin_b = 1'b1;
	logic [7:0] auto_seq_en = 8'hff, ch_power_en;
	logic [15:0] conv_data = 16'h0000, prog_word;
	logic sclk, cs_b, sdi, sdo, sdo_oe, sample_strobe, prog_reset, prog_req;
	logic [3:0] sample_channel, last_ch;
	amcs_mode_t mode;
	int err_total = 0, tests_run = 0, strobes = 0, resets = 0, reqs = 0;
	int m_mode = 0, m_scan = 0, m_man = 0;
	int oe_hits = 0;       // core cycles with sdo driven
	int exp_ch[$];         // channels expected at the coming strobes
	logic [15:0] exp_v;    // expected channel of the current strobe

	amcs_sequencer u_dut (.core_clk(core_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
		.sdi(sdi), .reset_powerdown_pin_b(reset_powerdown_pin_b), .auto_seq_en(auto_seq_en),
		.conv_data(conv_data), .sdo(sdo), .sdo_oe(sdo_oe), .mode(mode),
		.sample_strobe(sample_strobe), .sample_channel(sample_channel),
		.ch_power_en(ch_power_en), .prog_reset(prog_reset), .prog_req(prog_req),
		.prog_word(prog_word));
	amcs_host_model u_host (.sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo(sdo));

	always #50 core_clk = ~core_clk;

	// count the device pulses
	always @(posedge core_clk) begin
		if (sample_strobe === 1'b1) begin
			strobes++;
			last_ch = sample_channel;
			exp_v = 16'hffff;
			if (exp_ch.size() > 0) exp_v = 16'(exp_ch.pop_front());
			check(16'(sample_channel), exp_v);
		end
		if (prog_reset === 1'b1) resets++;
		if (prog_req === 1'b1) reqs++;
		if (sdo_oe === 1'b1) oe_hits++;
	end

	// -----------------------------------------------------------
	// model, comparison and ending
	// -----------------------------------------------------------
	function automatic int nxt(input int s);
		for (int i = 1; i <= 8; i++) if (auto_seq_en[(s + i) % 8]) return (s + i) % 8;
		return 0;
	endfunction : nxt

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	// one frame, then the model is stepped and compared
	task automatic run(input logic [15:0] w, input int n);
		logic [15:0] rx, cd, pe;
		int s0, r0, q0, o0, ch;
		cd = 16'($urandom);
		@(posedge core_clk) conv_data <= cd;
		s0 = strobes;
		r0 = resets;
		q0 = reqs;
		o0 = oe_hits;
		ch = (m_mode == 4) ? m_man : (m_mode == 3) ? m_scan : -1;
		if (ch >= 0) exp_ch.push_back(ch);
		if (m_mode == 3) m_scan = nxt(m_scan);
		u_host.frame(w, n, rx);
		repeat (10) @(posedge core_clk);
		check(16'(strobes - s0), (ch < 0) ? 16'h0000 : 16'h0001);
		check(16'(exp_ch.size()), 16'h0000);
		check(16'(oe_hits > o0), 16'h0001);
		check(16'(sdo_oe), 16'h0000);
		if (ch >= 0) check(16'(last_ch), 16'(ch));
		if (n >= 16) check(rx, (ch < 0) ? 16'hffff : cd);
		if (n >= 16) begin
			if (w == 16'h8200) m_mode = 1;
			else if (w == 16'h8300) m_mode = 2;
			else if (w == 16'h8500) begin
				m_mode = 0;
				m_scan = 0;
				check(16'(resets - r0), 16'h0001);
			end else if (w == 16'ha000) begin
				m_mode = 3;
				m_scan = nxt(7);
			end else if (w == 16'he000 || (w[15:13] == 3'h6 && w[9:0] == 10'h000)) begin
				m_mode = 4;
				m_man = (w == 16'he000) ? 8 : int'(w[12:10]);
			end else if (!w[15] && w != 16'h0000) begin
				check(16'(reqs - q0), 16'h0001);
				check(prog_word, w);
			end
		end
		check(16'(mode), 16'(m_mode));
		pe = (m_mode == 3) ? 16'(auto_seq_en) : (m_mode == 4) ? 16'h00ff : 16'h0000;
		check(16'(ch_power_en), pe);
	endtask : run

	// -----------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------
	initial begin
		void'($urandom(32'h2bca));
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge core_clk);
		check(16'(mode), 16'h0000);
		run(16'h8300, 16);
		run(16'h0000, 32);
		run(16'hc400, 32);
		run(16'h0000, 32);
		for (int c = 0; c <= 8; c++) begin
			run((c < 8) ? 16'(16'hc000 + c * 16'h0400) : 16'he000, 32);
		end
		run(16'h0000, 32);
		$display("manual test done");
		run(16'h8200, 16);
		@(posedge core_clk) auto_seq_en <= 8'($urandom_range(1, 255));
		run(16'ha000, 32);
		repeat (10) run(16'h0000, 32);
		run(16'ha000, 32);
		run(16'h0000, 32);
		run(16'h8700, 32);
		run(16'h8500, 16);
		run(16'h0000, 32);
		run(16'h0255, 16);
		run(16'hc000, 8);
		run(16'hc000, 32);
		$display("auto and reset test done");
		@(posedge core_clk) reset_powerdown_pin_b <= 1'b0;
		repeat (6) @(posedge core_clk);
		check(16'(mode), 16'h0002);
		check(16'(prog_reset), 16'h0001);
		@(posedge core_clk) reset_powerdown_pin_b <= 1'b1;
		repeat (6) @(posedge core_clk);
		m_mode = 0;
		run(16'h0000, 32);
		$display("pin test done");
		close_out();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		close_out();
	end
endmodule : adc_mode_channel_sequencer_tb_top
`default_nettype wire
